//--- shared/apri_pkg.sv
package apri_pkg;
    // ************************************************************
    // register offsets on the device register port
    // ************************************************************
    localparam logic [7:0] REG_MEM_CAPACITY = 8'hE0;
    localparam logic [7:0] REG_MEM_TYPE_A   = 8'hE1;
    localparam logic [7:0] REG_MEM_TYPE_B   = 8'hE2;
    localparam logic [7:0] REG_MEM_TYPE_C   = 8'hE3;
    localparam logic [7:0] REG_MEM_INIT     = 8'hE4;
    localparam int         INIT_BIT         = 0;
    localparam logic [7:0] CFG_RESET        = 8'h00;
    // ************************************************************
    // pixel formats
    // ************************************************************
    localparam int PAL_ENTRIES   = 64;
    localparam int IDX_W         = 6;
    localparam int COLOR_W       = 12;
    localparam int IDX_ALPHA_HI  = 7;
    localparam int IDX_ALPHA_LO  = 6;
    localparam int ARGB_ALPHA_HI = 15;
    localparam int ARGB_ALPHA_LO = 12;
    // ************************************************************
    // memory timing, 250 MHz clock
    // ************************************************************
    localparam int CLK_MHZ         = 250;
    localparam int INIT_WAIT_NS    = 200;
    localparam int INIT_WAIT_CYC   = (INIT_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int REFRESH_MS      = 64;
    localparam int MEM_ROWS        = 4096;
    localparam int MEM_WORDS       = 2 * 1024 * 1024;
    localparam int MEM_ADDR_W      = 21;
    // ************************************************************
    // host command registers, Avalon byte offsets
    // ************************************************************
    localparam logic [4:0] HC_CTRL    = 5'h00;
    localparam logic [4:0] HC_REGADR  = 5'h04;
    localparam logic [4:0] HC_DATA    = 5'h08;
    localparam logic [4:0] HC_STATUS  = 5'h0C;
    localparam logic [4:0] HC_IRQ     = 5'h10;
    localparam logic [4:0] HC_MASK    = 5'h14;
    localparam int CTRL_GO   = 0;
    localparam int CTRL_RD   = 1;
    localparam int CTRL_PIX  = 2;
    localparam int CTRL_INIT = 3;
    localparam int ST_BUSY   = 0;
    localparam int ST_READY  = 1;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_READY = 1;

    typedef enum logic [1:0] {
        MODE_IDX8  = 2'b00,
        MODE_ARGB8 = 2'b01,
        MODE_IDX16 = 2'b10,
        MODE_ARGB16 = 2'b11
    } apri_mode_t;

    typedef enum logic [2:0] {
        MC_IDLE    = 3'b000,
        MC_WAIT    = 3'b001,
        MC_PRECH   = 3'b010,
        MC_REFI    = 3'b011,
        MC_MODE    = 3'b100,
        MC_READY   = 3'b101
    } apri_mc_t;
endpackage

//--- shared/apri_if.sv
`timescale 1ns/1ps
`default_nettype none
interface apri_if;
    // register port
    logic       regWr;
    logic       regRd;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic       regAck;
    // pixel port
    logic        pixWr;
    logic [15:0] pixData;
    logic        pixAck;

    modport device (input regWr, regRd, regAddr, regWdata, pixWr, pixData,
                    output regRdata, regAck, pixAck);
    modport host (output regWr, regRd, regAddr, regWdata, pixWr, pixData,
                  input regRdata, regAck, pixAck);
endinterface
`default_nettype wire

//--- verilog/apri_mem_init.sv
`timescale 1ns/1ps
`default_nettype none
module apri_mem_init (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // control
    input  wire logic        start,
    input  wire logic [7:0]  refreshDiv,
    // status and sdram command
    output logic             ready,
    output logic [2:0]       sdramCmd
);
    apri_pkg::apri_mc_t stateR;
    logic [15:0] waitR;
    logic [15:0] refCntR;

    // ************************************************************
    // bring-up sequence then periodic refresh
    // ************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stateR   <= apri_pkg::MC_IDLE;
            waitR    <= 16'h0000;
            sdramCmd <= 3'h0;
        end else begin
            sdramCmd <= 3'h0;
            case (stateR)
                apri_pkg::MC_IDLE: begin
                    if (start) begin
                        stateR <= apri_pkg::MC_WAIT;
                        waitR  <= 16'(apri_pkg::INIT_WAIT_CYC);
                    end
                end
                apri_pkg::MC_WAIT: begin
                    if (waitR == 16'h0000) begin
                        stateR <= apri_pkg::MC_PRECH;
                    end else begin
                        waitR <= waitR - 16'h0001;
                    end
                end
                apri_pkg::MC_PRECH: begin
                    sdramCmd <= 3'h2;
                    stateR   <= apri_pkg::MC_REFI;
                    waitR    <= 16'h0001;
                end
                apri_pkg::MC_REFI: begin
                    sdramCmd <= 3'h1;
                    if (waitR == 16'h0000) begin
                        stateR <= apri_pkg::MC_MODE;
                    end else begin
                        waitR <= waitR - 16'h0001;
                    end
                end
                apri_pkg::MC_MODE: begin
                    sdramCmd <= 3'h3;
                    stateR   <= apri_pkg::MC_READY;
                end
                apri_pkg::MC_READY: begin
                    if (refCntR == 16'h0000) begin
                        sdramCmd <= 3'h1;
                    end
                end
                default: stateR <= apri_pkg::MC_IDLE;
            endcase
        end
    end

    // refresh pacing from programmed divider
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            refCntR <= 16'h0000;
        end else if (stateR != apri_pkg::MC_READY || refCntR == 16'h0000) begin
            refCntR <= {refreshDiv, 8'hFF};
        end else begin
            refCntR <= refCntR - 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ready <= 1'b0;
        end else begin
            ready <= (stateR == apri_pkg::MC_READY);
        end
    end
endmodule
`default_nettype wire

//--- verilog/apri_device.sv
// What this block does
// - palette of 64 entries, 4096 colours, opacity
// - indexed pixels resolve through loaded palette
// - 8-bit indexed: opacity 7:6, index 5:0
// - 8-bit argb: GB byte then AR byte
// - 16-bit indexed uses low byte only
// - 16-bit argb: A15:12 R11:8 G7:4 B3:0
// - alpha field is overlay opacity
// - display memory read continuously to panel
// - host places image data by writes
// - memory driven with sdram commands
// - host initializes before memory access
// - host writes capacity register first
// - host programs type registers next
// - periodic refresh paced by setting
// - writing bit0 starts memory init
// - bit0 reads one when init done
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
module apri_device (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // host link
    apri_if.device            link,
    // display side and sdram commands
    input  wire logic [1:0]   pixMode,
    input  wire logic         palWr,
    input  wire logic [5:0]   palIdx,
    input  wire logic [11:0]  palColor,
    output logic              dispValid,
    output logic [11:0]       dispColor,
    output logic [3:0]        dispAlpha,
    output logic [2:0]        sdramCmd
);
    logic [11:0] paletteR [apri_pkg::PAL_ENTRIES];
    logic [15:0] memR [256];
    logic [7:0]  capacityR;
    logic [7:0]  typeAR;
    logic [7:0]  typeBR;
    logic [7:0]  typeCR;
    logic        startR;
    logic        memReady;
    logic [7:0]  firstByteR;
    logic        haveFirstR;
    logic [7:0]  wrAdrR;
    logic [7:0]  rdAdrR;
    logic        pixGo;
    logic [15:0] pixWord;

    // ************************************************************
    // register port
    // ************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            capacityR <= apri_pkg::CFG_RESET;
            typeAR    <= apri_pkg::CFG_RESET;
            typeBR    <= apri_pkg::CFG_RESET;
            typeCR    <= apri_pkg::CFG_RESET;
            startR    <= 1'b0;
        end else begin
            startR <= 1'b0;
            if (link.regWr) begin
                case (link.regAddr)
                    apri_pkg::REG_MEM_CAPACITY: capacityR <= link.regWdata;
                    apri_pkg::REG_MEM_TYPE_A:   typeAR    <= link.regWdata;
                    apri_pkg::REG_MEM_TYPE_B:   typeBR    <= link.regWdata;
                    apri_pkg::REG_MEM_TYPE_C:   typeCR    <= link.regWdata;
                    apri_pkg::REG_MEM_INIT: startR <= link.regWdata[apri_pkg::INIT_BIT];
                    default: startR <= 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            link.regRdata <= 8'h00;
            link.regAck   <= 1'b0;
        end else begin
            link.regAck <= (link.regWr || link.regRd) && !link.regAck;
            case (link.regAddr)
                apri_pkg::REG_MEM_CAPACITY: link.regRdata <= capacityR;
                apri_pkg::REG_MEM_TYPE_A:   link.regRdata <= typeAR;
                apri_pkg::REG_MEM_TYPE_B:   link.regRdata <= typeBR;
                apri_pkg::REG_MEM_TYPE_C:   link.regRdata <= typeCR;
                apri_pkg::REG_MEM_INIT:     link.regRdata <= {7'h00, memReady};
                default:                    link.regRdata <= 8'h00;
            endcase
        end
    end

    apri_mem_init u_apri_mem_init (
        .mclk       (mclk),
        .resetn     (resetn),
        .start      (startR),
        .refreshDiv (typeCR),
        .ready      (memReady),
        .sdramCmd   (sdramCmd)
    );

    // ************************************************************
    // palette load
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (palWr) begin
            paletteR[palIdx] <= palColor;
        end
    end

    // ************************************************************
    // pixel assembly
    // ************************************************************
    always_comb begin
        pixGo   = 1'b0;
        pixWord = 16'h0000;
        case (apri_pkg::apri_mode_t'(pixMode))
            apri_pkg::MODE_IDX8: begin
                pixGo   = 1'b1;
                pixWord = {8'h00, link.pixData[7:0]};
            end
            apri_pkg::MODE_ARGB8: begin
                pixGo   = haveFirstR;
                pixWord = {link.pixData[7:0], firstByteR};
            end
            apri_pkg::MODE_IDX16: begin
                pixGo   = 1'b1;
                pixWord = {8'h00, link.pixData[7:0]};
            end
            apri_pkg::MODE_ARGB16: begin
                pixGo   = 1'b1;
                pixWord = link.pixData;
            end
            default: pixGo = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            firstByteR  <= 8'h00;
            haveFirstR  <= 1'b0;
            wrAdrR      <= 8'h00;
            link.pixAck <= 1'b0;
        end else begin
            link.pixAck <= 1'b0;
            if (link.pixWr && memReady && !link.pixAck) begin
                link.pixAck <= 1'b1;
                if (pixMode == 2'b01 && !haveFirstR) begin
                    firstByteR <= link.pixData[7:0];
                    haveFirstR <= 1'b1;
                end else begin
                    haveFirstR <= 1'b0;
                    wrAdrR     <= wrAdrR + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (link.pixWr && memReady && !link.pixAck && pixGo) begin
            memR[wrAdrR] <= pixWord;
        end
    end

    // ************************************************************
    // display engine: continuous scan
    // ************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdAdrR    <= 8'h00;
            dispValid <= 1'b0;
            dispColor <= 12'h000;
            dispAlpha <= 4'h0;
        end else begin
            dispValid <= memReady;
            if (memReady) begin
                rdAdrR <= rdAdrR + 8'h01;
                if (pixMode[0] == 1'b0) begin
                    dispColor <= paletteR[memR[rdAdrR][5:0]];
                    dispAlpha <= {memR[rdAdrR][7:6], 2'b00};
                end else begin
                    dispColor <= memR[rdAdrR][11:0];
                    dispAlpha <= memR[rdAdrR][15:12];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- verilog/apri_host.sv
`timescale 1ns/1ps
`default_nettype none
module apri_host (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // avalon slave
    input  wire logic [4:0]   avsAddress,
    input  wire logic         avsRead,
    input  wire logic         avsWrite,
    input  wire logic [31:0]  avsWritedata,
    output logic [31:0]       avsReaddata,
    output logic              avsWaitrequest,
    output logic              irq,
    // device link
    apri_if.host              link
);
    logic [7:0]  regAdrR;
    logic [15:0] dataR;
    logic [7:0]  rdBackR;
    logic        busyR;
    logic        readyR;
    logic [1:0]  irqR;
    logic [1:0]  maskR;
    logic        doneEv;
    logic        pollR;
    logic        avsAcc;

    assign avsAcc = (avsRead || avsWrite) && avsWaitrequest;

    // ************************************************************
    // avalon slave, one wait state
    // ************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            avsWaitrequest <= 1'b1;
            avsReaddata    <= 32'h0000_0000;
        end else begin
            avsWaitrequest <= !avsAcc;
            case (avsAddress)
                apri_pkg::HC_REGADR: avsReaddata <= {24'h0, regAdrR};
                apri_pkg::HC_DATA:   avsReaddata <= {16'h0, rdBackR, dataR[7:0]};
                apri_pkg::HC_STATUS: avsReaddata <= {30'h0, readyR, busyR};
                apri_pkg::HC_IRQ:    avsReaddata <= {30'h0, irqR};
                apri_pkg::HC_MASK:   avsReaddata <= {30'h0, maskR};
                default:             avsReaddata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            regAdrR <= 8'h00;
            dataR   <= 16'h0000;
            maskR   <= 2'b00;
        end else if (avsWrite && avsAcc) begin
            case (avsAddress)
                apri_pkg::HC_REGADR: regAdrR <= avsWritedata[7:0];
                apri_pkg::HC_DATA:   dataR   <= avsWritedata[15:0];
                apri_pkg::HC_MASK:   maskR   <= avsWritedata[1:0];
                default:             regAdrR <= regAdrR;
            endcase
        end
    end

    // ************************************************************
    // link sequencer
    // ************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            busyR         <= 1'b0;
            pollR         <= 1'b0;
            link.regWr    <= 1'b0;
            link.regRd    <= 1'b0;
            link.regAddr  <= 8'h00;
            link.regWdata <= 8'h00;
            link.pixWr    <= 1'b0;
            link.pixData  <= 16'h0000;
            rdBackR       <= 8'h00;
        end else if (!busyR) begin
            if (avsWrite && avsAcc && avsAddress == apri_pkg::HC_CTRL) begin
                busyR <= avsWritedata[apri_pkg::CTRL_GO] || avsWritedata[apri_pkg::CTRL_INIT];
                if (avsWritedata[apri_pkg::CTRL_INIT]) begin
                    link.regWr    <= 1'b1;
                    link.regAddr  <= apri_pkg::REG_MEM_INIT;
                    link.regWdata <= 8'h01;
                    pollR         <= 1'b1;
                end else if (avsWritedata[apri_pkg::CTRL_PIX]) begin
                    link.pixWr   <= readyR;
                    link.pixData <= dataR;
                    busyR        <= readyR;
                end else if (avsWritedata[apri_pkg::CTRL_GO]) begin
                    link.regWr    <= !avsWritedata[apri_pkg::CTRL_RD];
                    link.regRd    <= avsWritedata[apri_pkg::CTRL_RD];
                    link.regAddr  <= regAdrR;
                    link.regWdata <= dataR[7:0];
                end
            end
        end else if (link.regAck) begin
            link.regWr <= 1'b0;
            link.regRd <= 1'b0;
            rdBackR    <= link.regRdata;
            if (pollR && !link.regRdata[apri_pkg::INIT_BIT] && link.regRd) begin
                link.regRd <= 1'b0;
            end else if (pollR && link.regRdata[apri_pkg::INIT_BIT] && link.regRd) begin
                pollR <= 1'b0;
                busyR <= 1'b0;
            end else if (!pollR) begin
                busyR <= 1'b0;
            end
        end else if (pollR && !link.regWr && !link.regRd) begin
            link.regRd <= 1'b1;
        end else if (link.pixAck) begin
            link.pixWr <= 1'b0;
            busyR      <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            readyR <= 1'b0;
        end else if (pollR && link.regAck && link.regRd && link.regRdata[apri_pkg::INIT_BIT]) begin
            readyR <= 1'b1;
        end
    end

    assign doneEv = busyR && ((link.regAck && !pollR) || link.pixAck
                    || (pollR && link.regAck && link.regRd && link.regRdata[0]));

    // ************************************************************
    // interrupts, write one to clear, set wins
    // ************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irqR <= 2'b00;
            irq  <= 1'b0;
        end else begin
            logic [1:0] clr;
            logic [1:0] nxt;
            clr = (avsWrite && avsAcc && avsAddress == apri_pkg::HC_IRQ)
                ? avsWritedata[1:0] : 2'b00;
            nxt = irqR & ~clr;
            nxt[apri_pkg::IRQ_DONE]  = nxt[apri_pkg::IRQ_DONE] | doneEv;
            nxt[apri_pkg::IRQ_READY] = nxt[apri_pkg::IRQ_READY]
                | (pollR && link.regAck && link.regRd && link.regRdata[0]);
            irqR <= nxt;
            irq  <= |(nxt & maskR);
        end
    end
endmodule
`default_nettype wire

//--- tb/apri_properties.sv
`timescale 1ns/1ps
`default_nettype none
module apri_properties (
    // clock and reset
    input wire logic        mclk,
    input wire logic        resetn,
    // register port
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWdata,
    input wire logic [7:0]  regRdata,
    input wire logic        regAck,
    // pixel port
    input wire logic        pixWr,
    input wire logic [15:0] pixData,
    input wire logic        pixAck
);
    // ************************************************************
    // link protocol checks
    // ************************************************************
    logic capSeen_r;
    logic ready_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            capSeen_r <= 1'h0;
            ready_r   <= 1'h0;
        end else begin
            if (regWr && regAck && regAddr == apri_pkg::REG_MEM_CAPACITY) begin
                capSeen_r <= 1'h1;
            end
            if (regRd && regAck && regAddr == apri_pkg::REG_MEM_INIT && regRdata[0]) begin
                ready_r <= 1'h1;
            end
        end
    end

    chk_ack_one_cycle: assert property (regAck |=> !regAck)
        else $error("register ack longer than one cycle");
    chk_ack_answer: assert property (($rose(regWr) || $rose(regRd)) |=> regAck)
        else $error("register request not answered next cycle");
    chk_ack_cause: assert property (regAck |-> $past(regWr) || $past(regRd))
        else $error("register ack without request");
    chk_req_exclusive: assert property (!(regWr && regRd))
        else $error("register read and write together");
    chk_req_hold: assert property ((regWr || regRd) && !regAck |=>
        $stable(regAddr) && $stable(regWdata))
        else $error("register request changed before ack");
    chk_pix_pulse: assert property (pixAck |=> !pixAck)
        else $error("pixel ack longer than one cycle");
    chk_pix_cause: assert property (pixAck |-> $past(pixWr))
        else $error("pixel ack without request");
    chk_pix_hold: assert property (pixWr && !pixAck |=> $stable(pixData))
        else $error("pixel data changed before ack");
    chk_init_order: assert property (regWr && regAck && regAddr == apri_pkg::REG_MEM_INIT
        && regWdata[0] |-> capSeen_r)
        else $error("init started before capacity set");
    chk_pix_after_init: assert property (pixWr |-> ready_r)
        else $error("pixel write before init complete");
endmodule
`default_nettype wire

//--- tb/apri_tb.sv
`timescale 1ns/1ps
`default_nettype none
module argb_pixel_input_and_ram_init_tb;
    // ************************************************************
    // bench
    // ************************************************************
    logic        mclk;
    logic        resetn;
    logic [4:0]  avsAddress;
    logic        avsRead;
    logic        avsWrite;
    logic [31:0] avsWritedata;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic        irq;
    logic [1:0]  pixMode;
    logic        palWr;
    logic [5:0]  palIdx;
    logic [11:0] palColor;
    logic        dispValid;
    logic [11:0] dispColor;
    logic [3:0]  dispAlpha;
    logic [2:0]  sdramCmd;
    logic [31:0] rd;
    logic [7:0]  cfg [4];
    logic        sawPre, sawMode;
    int          nRef, ref0;
    int          n_errors, num_checks;

    apri_if link ();
    apri_host u_apri_host (.mclk(mclk), .resetn(resetn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .irq(irq), .link(link));
    apri_device u_apri_device (.mclk(mclk), .resetn(resetn), .link(link), .pixMode(pixMode),
        .palWr(palWr), .palIdx(palIdx), .palColor(palColor), .dispValid(dispValid),
        .dispColor(dispColor), .dispAlpha(dispAlpha), .sdramCmd(sdramCmd));
    apri_properties u_apri_properties (.mclk(mclk), .resetn(resetn), .regWr(link.regWr),
        .regRd(link.regRd), .regAddr(link.regAddr), .regWdata(link.regWdata),
        .regRdata(link.regRdata), .regAck(link.regAck), .pixWr(link.pixWr),
        .pixData(link.pixData), .pixAck(link.pixAck));

    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {sawPre, sawMode, nRef} <= '0;
        end else begin
            if (sdramCmd === 3'h1) nRef <= nRef + 1;
            if (sdramCmd === 3'h2) sawPre <= 1'h1;
            if (sdramCmd === 3'h3) sawMode <= 1'h1;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge mclk);
        while (avsWaitrequest !== 1'h0) @(posedge mclk);
        rd = avsReaddata;
        avsWrite <= 1'h0;
        avsRead <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic wait_idle;
        do av(1'h0, apri_pkg::HC_STATUS, 32'h0); while (rd[apri_pkg::ST_BUSY] !== 1'h0);
    endtask

    task automatic dreg(input logic wr, input logic [7:0] a, input logic [7:0] d);
        av(1'h1, apri_pkg::HC_REGADR, {24'h0, a});
        if (wr) av(1'h1, apri_pkg::HC_DATA, {24'h0, d});
        av(1'h1, apri_pkg::HC_CTRL, wr ? 32'h1 : 32'h3);
        wait_idle();
        if (!wr) begin
            av(1'h0, apri_pkg::HC_DATA, 32'h0);
            rd = {24'h0, rd[15:8]};
        end
    endtask

    task automatic pix(input logic [15:0] p);
        av(1'h1, apri_pkg::HC_DATA, {16'h0, p});
        av(1'h1, apri_pkg::HC_CTRL, 32'h4);
        wait_idle();
    endtask

    task automatic pal(input logic [5:0] i, input logic [11:0] c);
        palIdx <= i;
        palColor <= c;
        palWr <= 1'h1;
        @(posedge mclk);
        palWr <= 1'h0;
        @(posedge mclk);
    endtask

    // the scan wraps, so the pixel must show within a few passes
    task automatic see(input logic [11:0] c, input logic [3:0] a, input logic [3:0] m);
        logic hit;
        hit = 1'h0;
        repeat (600) begin
            @(posedge mclk);
            if (dispValid === 1'h1 && dispColor === c && (dispAlpha & m) === (a & m)) hit = 1'h1;
        end
        chk("display pixel", 32'h1, {31'h0, hit});
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        $display("timeout");
        end_sim();
    end

    initial begin
        {resetn, avsAddress, avsRead, avsWrite, avsWritedata, pixMode} <= '0;
        {palWr, palIdx, palColor} <= '0;
        cfg = '{8'h5A, 8'h21, 8'h33, 8'h01};
        repeat (6) @(posedge mclk);
        resetn <= 1'h1;
        @(posedge mclk);
        chk("waitrequest idle", 32'h1, {31'h0, avsWaitrequest});
        chk("display held", 32'h0, {31'h0, dispValid});
        av(1'h0, apri_pkg::HC_STATUS, 32'h0);
        chk("status reset", 32'h0, rd);
        av(1'h0, 5'h18, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("test reset done");
        for (int i = 0; i < 4; i++) dreg(1'h1, apri_pkg::REG_MEM_CAPACITY + i, cfg[i]);
        for (int i = 0; i < 4; i++) begin
            dreg(1'h0, apri_pkg::REG_MEM_CAPACITY + i, 8'h0);
            chk("config readback", {24'h0, cfg[i]}, rd);
        end
        chk("irq masked", 32'h0, {31'h0, irq});
        av(1'h1, apri_pkg::HC_MASK, 32'h1);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        av(1'h1, apri_pkg::HC_IRQ, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test config done");
        av(1'h1, apri_pkg::HC_MASK, 32'h2);
        av(1'h0, apri_pkg::HC_MASK, 32'h0);
        chk("mask readback", 32'h2, rd);
        av(1'h1, apri_pkg::HC_CTRL, 32'h8);
        do av(1'h0, apri_pkg::HC_STATUS, 32'h0); while (rd[apri_pkg::ST_READY] !== 1'h1);
        chk("ready irq", 32'h1, {31'h0, irq});
        dreg(1'h0, apri_pkg::REG_MEM_INIT, 8'h0);
        chk("init done bit", 32'h1, {31'h0, rd[0]});
        chk("sdram setup", 32'h3, {30'h0, sawPre, sawMode});
        av(1'h1, apri_pkg::HC_IRQ, 32'h3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        ref0 = nRef;
        repeat (520) @(posedge mclk);
        chk("refresh seen", 32'h1, {31'h0, nRef > ref0});
        $display("test init done");
        pal(6'h05, 12'h3C7);
        pal(6'h3F, 12'h812);
        pix(16'h00C5);
        see(12'h3C7, 4'hC, 4'hC);
        pixMode <= 2'h1;
        pix(16'h0036);
        pix(16'h00A9);
        see(12'h936, 4'hA, 4'hF);
        pixMode <= 2'h2;
        pix(16'hFF7F);
        see(12'h812, 4'h4, 4'hC);
        pixMode <= 2'h3;
        pix(16'h9ABC);
        see(12'hABC, 4'h9, 4'hF);
        $display("test pixels done");
        end_sim();
    end
endmodule
`default_nettype wire
